// File: verilog/sensor_alert_pkg.sv
// Behaviour
// - Temperature low level, 8-bit RW, resets 0x01
// - Temperature high level, 8-bit RW, resets 0xff
// - Temperature code/256*165-40 gives degrees Celsius
// - Humidity low level, 8-bit RW, resets zero
// - Humidity high level, 8-bit RW, resets 0xff
// - Humidity code/256*100 gives percent RH
// - Setup bit 7 soft-resets, then self-clears
// - Rate code 000 means one-shot mode
// - Nonzero rate codes pick continuous sample rate
// - Setup bit 3 switches heater on/off
// - Setup bit 2 enables alert pin drive
// - Setup bit 1 picks alert pin polarity
// - Setup bit 0: clear-on-read or comparator
// - Device setup at 0x0e, RW, resets zero
// - Measurement setup field layout at 0x0f
// - Alert enables act only with pin enabled
// - Trigger starts measurement, self-clears on start
// - Resolution codes 00/01/10 give 14/11/9 bits
package sensor_alert_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_IN_NS = 1000000;
    localparam int unsigned MS_CYCLES_DEFAULT = MS_IN_NS / CLK_PERIOD_NS;

    // Register offsets
    localparam logic [7:0] ADDR_TEMP_LOW = 8'h0a;
    localparam logic [7:0] ADDR_TEMP_HIGH = 8'h0b;
    localparam logic [7:0] ADDR_HUM_LOW = 8'h0c;
    localparam logic [7:0] ADDR_HUM_HIGH = 8'h0d;
    localparam logic [7:0] ADDR_DEV_SETUP = 8'h0e;
    localparam logic [7:0] ADDR_MEAS_SETUP = 8'h0f;

    // Reset values
    localparam logic [7:0] RST_TEMP_LOW = 8'h01;
    localparam logic [7:0] RST_TEMP_HIGH = 8'hff;
    localparam logic [7:0] RST_HUM_LOW = 8'h00;
    localparam logic [7:0] RST_HUM_HIGH = 8'hff;
    localparam logic [7:0] RST_DEV_SETUP = 8'h00;
    localparam logic [7:0] RST_MEAS_SETUP = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Conversion rate codes and sample periods in ms
    localparam logic [2:0] RATE_ONE_SHOT = 3'h0;
    localparam logic [31:0] RATE_PERIOD_MS [8] = '{
        32'h0, 32'd120000, 32'd60000, 32'd10000,
        32'd5000, 32'd1000, 32'd500, 32'd200
    };

    // Resolution codes and widths
    localparam logic [1:0] RES_14 = 2'h0;
    localparam logic [1:0] RES_11 = 2'h1;
    localparam logic [1:0] RES_9 = 2'h2;
    localparam logic [3:0] RES_BITS_14 = 4'he;
    localparam logic [3:0] RES_BITS_11 = 4'hb;
    localparam logic [3:0] RES_BITS_9 = 4'h9;
    localparam logic [3:0] RES_BITS_NA = 4'h0;

    localparam int unsigned NUM_CHAN = 2;
    localparam int unsigned CHAN_TEMP = 0;
    localparam int unsigned CHAN_HUM = 1;

    typedef struct packed {
        logic soft_reset_request;
        logic [2:0] conversion_rate_select;
        logic heater_on;
        logic alert_pin_enable;
        logic alert_polarity;
        logic alert_behaviour;
    } device_setup_s;

    typedef struct packed {
        logic [1:0] temperature_resolution;
        logic [1:0] humidity_resolution;
        logic reserved;
        logic [1:0] measurement_selection;
        logic measure_trigger;
    } measurement_setup_s;

    typedef struct packed {
        logic temp_high_alert_enable;
        logic temp_low_alert_enable;
        logic hum_high_alert_enable;
        logic hum_low_alert_enable;
    } alert_enable_s;

    typedef struct packed {
        logic [15:0] temperature;
        logic [15:0] humidity;
    } meas_result_s;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_RUN = 2'b10
    } conv_state_e;

endpackage

// File: verilog/alert_compare.sv
`timescale 1ns/1ps
module alert_compare import sensor_alert_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Control
    input wire logic clear_all,
    input wire logic comparator_mode,
    input wire logic flag_read,
    // Sample and levels
    input wire logic sample_valid,
    input wire logic [7:0] sample,
    input wire logic [7:0] level_low,
    input wire logic [7:0] level_high,
    // Flags
    output logic low_flag_q,
    output logic high_flag_q
);

    logic below;
    logic above;
    logic low_flag_d;
    logic high_flag_d;
    logic read_clear;

    assign below = sample < level_low;
    assign above = sample > level_high;
    assign read_clear = flag_read && !comparator_mode;

    // Comparator follows each sample; latched mode keeps set over clear
    assign low_flag_d = comparator_mode ? (sample_valid ? below : low_flag_q)
        : ((sample_valid && below) || (low_flag_q && !read_clear));
    assign high_flag_d = comparator_mode ? (sample_valid ? above : high_flag_q)
        : ((sample_valid && above) || (high_flag_q && !read_clear));

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            low_flag_q <= 1'b0;
            high_flag_q <= 1'b0;
        end else if (clear_all) begin
            low_flag_q <= 1'b0;
            high_flag_q <= 1'b0;
        end else begin
            low_flag_q <= low_flag_d;
            high_flag_q <= high_flag_d;
        end
    end

    a_low_flag_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (sample_valid && below && !clear_all) |=> low_flag_q)
        else $error("low flag not set by sample below level");

    a_read_clears_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (flag_read && !comparator_mode && !sample_valid) |=> (!low_flag_q && !high_flag_q))
        else $error("clear-on-read did not clear flags");

    a_cmp_tracks_high: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (sample_valid && comparator_mode && !above && !clear_all) |=> !high_flag_q)
        else $error("comparator mode high flag did not follow sample");

endmodule // alert_compare

// File: verilog/sensor_alert_threshold_config_regs.sv
`timescale 1ns/1ps
module sensor_alert_threshold_config_regs import sensor_alert_pkg::*; #(
    parameter int unsigned CYCLES_PER_MS = MS_CYCLES_DEFAULT
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data_q,
    // Alert enables and status read
    input wire alert_enable_s alert_enable,
    input wire logic alert_status_read,
    // New conversion results
    input wire logic result_valid,
    input wire meas_result_s result,
    // Conversion control
    output logic conv_start_q,
    output logic conv_continuous_q,
    output logic soft_reset_pulse,
    // Setup outputs
    output logic heater_on,
    output logic [3:0] temp_res_bits,
    output logic [3:0] hum_res_bits,
    output logic [1:0] measurement_selection,
    // Alert flags, temp low/high then hum low/high
    output logic [3:0] alert_flags,
    // Ready/alert pin
    output logic ready_alert_out_q,
    output logic ready_alert_oe_q
);

    logic [7:0] temp_low_q;
    logic [7:0] temp_high_q;
    logic [7:0] hum_low_q;
    logic [7:0] hum_high_q;
    device_setup_s dev_q;
    device_setup_s dev_d;
    measurement_setup_s meas_q;
    measurement_setup_s meas_d;
    conv_state_e state_q;
    conv_state_e state_d;
    logic [39:0] timer_q;
    logic [39:0] timer_d;
    logic [39:0] period_cycles;
    logic timer_done;
    logic start_d;
    logic sreset;

    // Address decode
    logic wr_temp_low;
    logic wr_temp_high;
    logic wr_hum_low;
    logic wr_hum_high;
    logic wr_dev;
    logic wr_meas;
    logic [7:0] rd_mux;

    assign wr_temp_low = reg_wr_en && (reg_addr == ADDR_TEMP_LOW);
    assign wr_temp_high = reg_wr_en && (reg_addr == ADDR_TEMP_HIGH);
    assign wr_hum_low = reg_wr_en && (reg_addr == ADDR_HUM_LOW);
    assign wr_hum_high = reg_wr_en && (reg_addr == ADDR_HUM_HIGH);
    assign wr_dev = reg_wr_en && (reg_addr == ADDR_DEV_SETUP);
    assign wr_meas = reg_wr_en && (reg_addr == ADDR_MEAS_SETUP);

    assign rd_mux = (reg_addr == ADDR_TEMP_LOW) ? temp_low_q :
        (reg_addr == ADDR_TEMP_HIGH) ? temp_high_q :
        (reg_addr == ADDR_HUM_LOW) ? hum_low_q :
        (reg_addr == ADDR_HUM_HIGH) ? hum_high_q :
        (reg_addr == ADDR_DEV_SETUP) ? 8'(dev_q) :
        (reg_addr == ADDR_MEAS_SETUP) ? 8'(meas_q) :
        RD_UNMAPPED;

    // Soft reset request held one cycle, then all registers except read data and the ready/alert pin outputs return to defaults
    assign sreset = dev_q.soft_reset_request;
    assign soft_reset_pulse = sreset;

    // Threshold registers; codes are raw sensor codes, scaled outside
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            temp_low_q <= RST_TEMP_LOW;
            temp_high_q <= RST_TEMP_HIGH;
            hum_low_q <= RST_HUM_LOW;
            hum_high_q <= RST_HUM_HIGH;
        end else if (sreset) begin
            temp_low_q <= RST_TEMP_LOW;
            temp_high_q <= RST_TEMP_HIGH;
            hum_low_q <= RST_HUM_LOW;
            hum_high_q <= RST_HUM_HIGH;
        end else begin
            if (wr_temp_low) begin
                temp_low_q <= reg_wr_data;
            end
            if (wr_temp_high) begin
                temp_high_q <= reg_wr_data;
            end
            if (wr_hum_low) begin
                hum_low_q <= reg_wr_data;
            end
            if (wr_hum_high) begin
                hum_high_q <= reg_wr_data;
            end
        end
    end

    // Setup bytes
    assign dev_d = wr_dev ? device_setup_s'(reg_wr_data) : dev_q;

    always_comb begin
        meas_d = meas_q;
        if (start_d && state_q == CONV_IDLE || meas_q.measure_trigger) begin
            meas_d.measure_trigger = 1'b0;
        end
        if (wr_meas) begin
            meas_d = measurement_setup_s'(reg_wr_data);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dev_q <= device_setup_s'(RST_DEV_SETUP);
            meas_q <= measurement_setup_s'(RST_MEAS_SETUP);
        end else if (sreset) begin
            dev_q <= device_setup_s'(RST_DEV_SETUP);
            meas_q <= measurement_setup_s'(RST_MEAS_SETUP);
        end else begin
            dev_q <= dev_d;
            meas_q <= meas_d;
        end
    end

    // Setup fields to the rest of the sensor
    assign heater_on = dev_q.heater_on;
    assign measurement_selection = meas_q.measurement_selection;

    assign temp_res_bits = (meas_q.temperature_resolution == RES_14) ? RES_BITS_14 :
        (meas_q.temperature_resolution == RES_11) ? RES_BITS_11 :
        (meas_q.temperature_resolution == RES_9) ? RES_BITS_9 : RES_BITS_NA;
    assign hum_res_bits = (meas_q.humidity_resolution == RES_14) ? RES_BITS_14 :
        (meas_q.humidity_resolution == RES_11) ? RES_BITS_11 :
        (meas_q.humidity_resolution == RES_9) ? RES_BITS_9 : RES_BITS_NA;

    // Sample rate timer
    assign period_cycles = 40'(RATE_PERIOD_MS[dev_q.conversion_rate_select]) * 40'(CYCLES_PER_MS);
    assign timer_done = timer_q >= (period_cycles - 40'h1);

    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        start_d = 1'b0;
        case (state_q)
            CONV_IDLE: begin
                timer_d = '0;
                if (meas_q.measure_trigger) begin
                    start_d = 1'b1;
                    if (dev_q.conversion_rate_select != RATE_ONE_SHOT) begin
                        state_d = CONV_RUN;
                    end
                end
            end
            CONV_RUN: begin
                if (dev_q.conversion_rate_select == RATE_ONE_SHOT) begin
                    state_d = CONV_IDLE;
                    timer_d = '0;
                end else if (meas_q.measure_trigger || timer_done) begin
                    start_d = 1'b1;
                    timer_d = '0;
                end else begin
                    timer_d = timer_q + 40'h1;
                end
            end
            default: begin
                state_d = CONV_IDLE;
                timer_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= CONV_IDLE;
            timer_q <= '0;
            conv_start_q <= 1'b0;
        end else if (sreset) begin
            state_q <= CONV_IDLE;
            timer_q <= '0;
            conv_start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            conv_start_q <= start_d;
        end
    end

    assign conv_continuous_q = (state_q == CONV_RUN);

    // Threshold comparison per channel
    logic [7:0] chan_sample [NUM_CHAN];
    logic [7:0] chan_low [NUM_CHAN];
    logic [7:0] chan_high [NUM_CHAN];
    logic [NUM_CHAN-1:0] low_flag;
    logic [NUM_CHAN-1:0] high_flag;

    assign chan_sample[CHAN_TEMP] = result.temperature[15:8];
    assign chan_sample[CHAN_HUM] = result.humidity[15:8];
    assign chan_low[CHAN_TEMP] = temp_low_q;
    assign chan_low[CHAN_HUM] = hum_low_q;
    assign chan_high[CHAN_TEMP] = temp_high_q;
    assign chan_high[CHAN_HUM] = hum_high_q;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
            alert_compare u_cmp (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .clear_all(sreset),
                .comparator_mode(dev_q.alert_behaviour),
                .flag_read(alert_status_read),
                .sample_valid(result_valid),
                .sample(chan_sample[ch]),
                .level_low(chan_low[ch]),
                .level_high(chan_high[ch]),
                .low_flag_q(low_flag[ch]),
                .high_flag_q(high_flag[ch])
            );
        end
    endgenerate

    assign alert_flags = {high_flag[CHAN_HUM], low_flag[CHAN_HUM], high_flag[CHAN_TEMP], low_flag[CHAN_TEMP]};

    // Ready/alert pin
    logic alert_active;

    assign alert_active = dev_q.alert_pin_enable && (
        (alert_enable.temp_low_alert_enable && low_flag[CHAN_TEMP]) ||
        (alert_enable.temp_high_alert_enable && high_flag[CHAN_TEMP]) ||
        (alert_enable.hum_low_alert_enable && low_flag[CHAN_HUM]) ||
        (alert_enable.hum_high_alert_enable && high_flag[CHAN_HUM]));

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ready_alert_out_q <= 1'b1;
            ready_alert_oe_q <= 1'b0;
        end else begin
            ready_alert_out_q <= dev_q.alert_polarity ? alert_active : !alert_active;
            ready_alert_oe_q <= dev_q.alert_pin_enable;
        end
    end

    // Register read data
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rd_data_q <= RD_UNMAPPED;
        end else if (reg_rd_en) begin
            reg_rd_data_q <= rd_mux;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_soft_reset_write;
        wr_dev && reg_wr_data[7] && !sreset;
    endsequence

    sequence s_oneshot_trigger;
        wr_meas && reg_wr_data[0] && !sreset && state_q == CONV_IDLE;
    endsequence

    a_sreset_self_clear: assert property (
        s_soft_reset_write |=> sreset ##1 (!sreset && 8'(dev_q) == RST_DEV_SETUP))
        else $error("soft reset bit did not self-clear");

    a_sreset_defaults: assert property (
        sreset |=> (temp_low_q == RST_TEMP_LOW && temp_high_q == RST_TEMP_HIGH
            && hum_low_q == RST_HUM_LOW && hum_high_q == RST_HUM_HIGH))
        else $error("soft reset did not restore thresholds");

    a_level_write: assert property (
        (wr_hum_low && !sreset) |=> hum_low_q == $past(reg_wr_data))
        else $error("humidity low level write lost");

    a_dev_readback: assert property (
        (reg_rd_en && reg_addr == ADDR_DEV_SETUP) |=> reg_rd_data_q == $past(8'(dev_q)))
        else $error("device setup readback mismatch");

    a_trigger_start: assert property (
        s_oneshot_trigger |=> ##1 (conv_start_q && !meas_q.measure_trigger))
        else $error("trigger did not start and self-clear");

    a_oneshot_single: assert property (
        (conv_start_q && dev_q.conversion_rate_select == RATE_ONE_SHOT && !meas_q.measure_trigger)
            |=> !conv_start_q)
        else $error("one-shot mode started twice");

    a_pin_hiz: assert property (
        !dev_q.alert_pin_enable |=> !ready_alert_oe_q)
        else $error("alert pin driven while disabled");

    a_pin_polarity: assert property (
        (dev_q.alert_pin_enable && !alert_active && !dev_q.alert_polarity) |=> ready_alert_out_q)
        else $error("idle active-low pin not high");

endmodule // sensor_alert_threshold_config_regs

// File: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clk_sys,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rd_data_q
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end

    // Released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        @(negedge clk_sys);
        d = reg_rd_data_q;
    endtask
endmodule // host_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top import sensor_alert_pkg::*; ();
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data_q;
    logic reg_wr_en, reg_rd_en;
    alert_enable_s alert_enable = '0;
    logic alert_status_read = 1'b0;
    logic result_valid = 1'b0;
    meas_result_s result = '0;
    logic conv_start_q, conv_continuous_q, soft_reset_pulse, heater_on;
    logic [3:0] temp_res_bits, hum_res_bits, alert_flags;
    logic [1:0] measurement_selection;
    logic ready_alert_out_q, ready_alert_oe_q;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] rv [7] = '{8'h01, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};

    host_model host_model_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q));

    sensor_alert_threshold_config_regs #(.CYCLES_PER_MS(10)) sensor_alert_threshold_config_regs_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q),
        .alert_enable(alert_enable), .alert_status_read(alert_status_read),
        .result_valid(result_valid), .result(result), .conv_start_q(conv_start_q),
        .conv_continuous_q(conv_continuous_q), .soft_reset_pulse(soft_reset_pulse),
        .heater_on(heater_on), .temp_res_bits(temp_res_bits), .hum_res_bits(hum_res_bits),
        .measurement_selection(measurement_selection), .alert_flags(alert_flags),
        .ready_alert_out_q(ready_alert_out_q), .ready_alert_oe_q(ready_alert_oe_q));

    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            end_of_test();
        end
    end

    function automatic logic [3:0] res_bits(input logic [1:0] c);
        return (c == 2'h0) ? 4'he : (c == 2'h1) ? 4'hb : (c == 2'h2) ? 4'h9 : 4'h0;
    endfunction

    // Flag order: hum high, hum low, temp high, temp low
    function automatic logic [3:0] flags(input logic [7:0] t, h, tl, th, hl, hh);
        return {h > hh, h < hl, t > th, t < tl};
    endfunction

    task automatic send(input logic [7:0] t, input logic [7:0] h);
        @(negedge clk_sys);
        result = {t, 8'($urandom), h, 8'($urandom)};
        result_valid = 1'b1;
        @(negedge clk_sys);
        result_valid = 1'b0;
    endtask

    // Interval in cycles up to the next start pulse
    task automatic wait_start(input int lim, output int k);
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (conv_start_q !== 1'b1 && k < lim);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        logic [7:0] a, v, d, tl, th, hl, hh, t, h;
        logic [3:0] e, m;
        logic pe, pol, act, seen;
        int k;
        void'($urandom(32'h888a));
        repeat (3) @(negedge clk_sys);
        arst_n = 1'b1;
        `CHK("oe", 1'b0, ready_alert_oe_q)
        for (int i = 0; i < 7; i++) begin
            host_model_i.rd(8'h0a + 8'(i), d);
            `CHK("reset value", rv[i], d)
        end
        $display("test reset values done");
        host_model_i.wr(8'h10, 8'h5a);
        for (int i = 0; i < 25; i++) begin
            a = 8'h0a + 8'($urandom % 5);
            v = 8'($urandom);
            if (a == 8'h0e) v[7:4] = 4'h0;
            host_model_i.wr(a, v);
            host_model_i.rd(a, d);
            `CHK("read back", v, d)
            if (a == 8'h0e) begin
                `CHK("heater", v[3], heater_on)
                `CHK("oe", v[2], ready_alert_oe_q)
            end
        end
        host_model_i.rd(8'h10, d);
        `CHK("unmapped", 8'h00, d)
        $display("test read write done");
        for (int c = 0; c < 4; c++) begin
            v = {2'(c), 2'(~c), 1'($urandom), 2'(c), 1'b0};
            host_model_i.wr(8'h0f, v);
            host_model_i.rd(8'h0f, d);
            `CHK("meas setup", v, d)
            `CHK("temp res", res_bits(v[7:6]), temp_res_bits)
            `CHK("hum res", res_bits(v[5:4]), hum_res_bits)
            `CHK("meas sel", v[2:1], measurement_selection)
        end
        host_model_i.wr(8'h0e, 8'h00);
        host_model_i.wr(8'h0f, 8'h01);
        `CHK("start", 1'b0, conv_start_q)
        @(negedge clk_sys);
        `CHK("start", 1'b1, conv_start_q)
        @(negedge clk_sys);
        `CHK("start", 1'b0, conv_start_q)
        @(negedge clk_sys);
        `CHK("start", 1'b0, conv_start_q)
        host_model_i.rd(8'h0f, d);
        `CHK("trigger clear", 8'h00, d)
        $display("test trigger done");
        for (int c = 0; c < 8; c++) begin
            host_model_i.wr(8'h0e, {1'b0, 3'(c), 4'h0});
            // Continuous running only begins once triggered
            if (c != 0) host_model_i.wr(8'h0f, 8'h01);
            @(negedge clk_sys);
            `CHK("continuous", c != 0, conv_continuous_q)
            if (c >= 6) begin
                wait_start(6000, k);
                wait_start(6000, k);
                `CHK("period", (c == 6) ? 5000 : 2000, k)
            end
        end
        host_model_i.wr(8'h0e, 8'h00);
        $display("test rate done");
        for (int i = 0; i < 30; i++) begin
            {tl, th, hl, hh, t, h} = 48'({$urandom, $urandom});
            if (i == 0) {t, h} = {tl, hh};
            pe = 1'($urandom);
            pol = 1'($urandom);
            alert_enable = 4'($urandom);
            host_model_i.wr(8'h0a, tl);
            host_model_i.wr(8'h0b, th);
            host_model_i.wr(8'h0c, hl);
            host_model_i.wr(8'h0d, hh);
            host_model_i.wr(8'h0e, {5'h00, pe, pol, 1'b1});
            send(t, h);
            e = flags(t, h, tl, th, hl, hh);
            m = {alert_enable.hum_high_alert_enable, alert_enable.hum_low_alert_enable,
                alert_enable.temp_high_alert_enable, alert_enable.temp_low_alert_enable};
            `CHK("flags", e, alert_flags)
            @(negedge clk_sys);
            act = pe && ((e & m) != 4'h0);
            `CHK("oe", pe, ready_alert_oe_q)
            if (pe) `CHK("pin", pol ? act : ~act, ready_alert_out_q)
        end
        $display("test comparator done");
        alert_enable = 4'hf;
        host_model_i.wr(8'h0a, 8'h80);
        host_model_i.wr(8'h0b, 8'hff);
        host_model_i.wr(8'h0c, 8'h00);
        host_model_i.wr(8'h0d, 8'hff);
        host_model_i.wr(8'h0e, 8'h06);
        // Drop flags latched by the comparator test
        alert_status_read = 1'b1;
        @(negedge clk_sys);
        alert_status_read = 1'b0;
        send(8'h10, 8'h40);
        send(8'h90, 8'h40);
        @(negedge clk_sys);
        `CHK("held flag", 4'h1, alert_flags)
        `CHK("pin", 1'b1, ready_alert_out_q)
        alert_status_read = 1'b1;
        @(negedge clk_sys);
        alert_status_read = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK("cleared flag", 4'h0, alert_flags)
        `CHK("pin", 1'b0, ready_alert_out_q)
        $display("test clear on read done");
        host_model_i.wr(8'h0a, 8'h33);
        host_model_i.wr(8'h0e, 8'h80);
        seen = 1'b0;
        repeat (4) begin
            if (soft_reset_pulse === 1'b1) seen = 1'b1;
            @(negedge clk_sys);
        end
        `CHK("soft reset seen", 1'b1, seen)
        host_model_i.rd(8'h0a, d);
        `CHK("temp low after reset", 8'h01, d)
        host_model_i.rd(8'h0e, d);
        `CHK("setup after reset", 8'h00, d)
        $display("test soft reset done");
        end_of_test();
    end
endmodule // tb_top
